/* File: motion_cfg_params.svh */
// Purpose: constants for the motion feature configuration bank
// Assumes: 8-bit register port, 100 MHz core clock
// Notes:   offsets are byte addresses on the plain register port
//
// Behaviour
// - an interrupt is raised when the long counter becomes equal to the 16-bit timeout.
// - the timeout is a low byte at 7Ah and a high byte at 7Bh, both read-write, reset zero.
// - with the overflow-only bit set the step interrupt fires only on count overflow.
// - false-step rejection works only while the advanced step enable is one.
// - advanced detection works only when rejection and advanced step enable are both one.
// - the step counter does not move until the debounce number of steps is seen.
// - the 16-bit step window counts in units of 6.4 ms.
// - calibration registers are reloaded automatically at power-up.
`ifndef MOTION_CFG_PARAMS_SVH
`define MOTION_CFG_PARAMS_SVH

// register offsets
`define OFS_FEATURE_ENABLE_B 8'h05
`define OFS_LC_LIMIT_LO      8'h7a
`define OFS_LC_LIMIT_HI      8'h7b
`define OFS_PROGRAM_COUNT    8'h7c
`define OFS_PROGRAM_BASE_LO  8'h7e
`define OFS_PROGRAM_BASE_HI  8'h7f
`define OFS_STEP_COMMAND     8'h83
`define OFS_STEP_DEBOUNCE    8'h84
`define OFS_STEP_WINDOW_LO   8'hd0
`define OFS_STEP_WINDOW_HI   8'hd1
`define OFS_IRQ_STATUS       8'he0
`define OFS_IRQ_MASK         8'he1
`define OFS_CAL_TRIM         8'he2

// reset values and step command write mask
`define RST_ZERO             8'h00
`define RST_STEP_DEBOUNCE    8'h0a
`define STEP_CMD_WMASK       8'h0d

// field positions
`define BIT_STEP_ADV_EN      3
`define BIT_IRQ_LC_MATCH     0
`define BIT_IRQ_STEP         1
`define BIT_IRQ_STEP_OVF     2

// timing
`define CLK_PERIOD_NS        10
`define STEP_LSB_NS          6400000

`endif

/* File: motion_cfg_pkg.sv */
// Purpose: types for the motion feature configuration bank
// Assumes: constants come from motion_cfg_params.svh
// Notes:   none
package motion_cfg_pkg;

  // one request on the plain register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // step command register layout
  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic       carry_count_en;
    logic       false_step_reject_en;
    logic       rsvd_lo;
    logic       advanced_detect_en;
  } step_cmd_t;

endpackage : motion_cfg_pkg

/* File: motion_fsm_pedometer_config.sv */
// Purpose: configuration bank for the motion state machine and pedometer
// Assumes: engine inputs are on core_clk; register port is synchronous
// Notes:   read data stand only in the cycle after the read strobe
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "motion_cfg_params.svh"

module motion_fsm_pedometer_config
  import motion_cfg_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `STEP_LSB_NS / `CLK_PERIOD_NS,
  parameter logic [7:0]  CAL_TRIM_DEFAULT = 8'h5a  // factory value, arbitrary
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // register port
  input  wire reg_req_t    reg_req,
  output logic [7:0]       rd_data,
  // state machine engine
  input  wire logic [15:0] long_count,
  output logic [15:0]      long_count_limit,
  output logic [7:0]       program_count,
  output logic [15:0]      program_base,
  // pedometer engine
  input  wire logic        step_detected,
  output logic [15:0]      step_count,
  output logic             false_step_reject_active,
  output logic             advanced_detect_active,
  output logic [7:0]       cal_trim,
  // interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_r;
  logic rst_n_r;

  // two flops so release is clean against core_clk
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0] feature_enable_b_r;
  logic [7:0] long_count_limit_lo_r;
  logic [7:0] long_count_limit_hi_r;
  logic [7:0] program_count_r;
  logic [7:0] program_base_lo_r;
  logic [7:0] program_base_hi_r;
  step_cmd_t  step_command_r;
  logic [7:0] step_debounce_r;
  logic [7:0] step_window_lo_r;
  logic [7:0] step_window_hi_r;
  logic [7:0] irq_mask_r;
  logic [7:0] cal_trim_r;

  logic wr_en;
  logic rd_en;

  assign wr_en = reg_req.wr;
  assign rd_en = reg_req.rd;

  // configuration writes; unmapped offsets are ignored
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      feature_enable_b_r    <= `RST_ZERO;
      long_count_limit_lo_r <= `RST_ZERO;
      long_count_limit_hi_r <= `RST_ZERO;
      program_count_r       <= `RST_ZERO;
      program_base_lo_r     <= `RST_ZERO;
      program_base_hi_r     <= `RST_ZERO;
      step_command_r        <= step_cmd_t'(`RST_ZERO);
      step_debounce_r       <= `RST_STEP_DEBOUNCE;
      step_window_lo_r      <= `RST_ZERO;
      step_window_hi_r      <= `RST_ZERO;
      irq_mask_r            <= `RST_ZERO;
    end
    else if (wr_en)
    begin
      case (reg_req.addr)
        `OFS_FEATURE_ENABLE_B: feature_enable_b_r    <= reg_req.wdata;
        `OFS_LC_LIMIT_LO:      long_count_limit_lo_r <= reg_req.wdata;
        `OFS_LC_LIMIT_HI:      long_count_limit_hi_r <= reg_req.wdata;
        `OFS_PROGRAM_COUNT:    program_count_r       <= reg_req.wdata;
        `OFS_PROGRAM_BASE_LO:  program_base_lo_r     <= reg_req.wdata;
        `OFS_PROGRAM_BASE_HI:  program_base_hi_r     <= reg_req.wdata;
        // reserved bits are held at zero whatever is written
        `OFS_STEP_COMMAND:     step_command_r <= step_cmd_t'(reg_req.wdata & `STEP_CMD_WMASK);
        `OFS_STEP_DEBOUNCE:    step_debounce_r       <= reg_req.wdata;
        `OFS_STEP_WINDOW_LO:   step_window_lo_r      <= reg_req.wdata;
        `OFS_STEP_WINDOW_HI:   step_window_hi_r      <= reg_req.wdata;
        `OFS_IRQ_MASK:         irq_mask_r            <= reg_req.wdata;
        default:               irq_mask_r            <= irq_mask_r;
      endcase
    end
  end

  // calibration trim restored on every power-up reset
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cal_trim_r <= CAL_TRIM_DEFAULT;
    end
    else if (wr_en && reg_req.addr == `OFS_CAL_TRIM)
    begin
      cal_trim_r <= reg_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multi-byte settings

  logic [15:0] lc_limit;
  logic [15:0] window_period;

  assign lc_limit      = {long_count_limit_hi_r, long_count_limit_lo_r};
  assign window_period = {step_window_hi_r, step_window_lo_r};

  // mirror settings to the engines
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      long_count_limit <= 16'h0000;
      program_count    <= `RST_ZERO;
      program_base     <= 16'h0000;
      cal_trim         <= `RST_ZERO;
    end
    else
    begin
      long_count_limit <= lc_limit;
      program_count    <= program_count_r;
      program_base     <= {program_base_hi_r, program_base_lo_r};
      cal_trim         <= cal_trim_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pedometer option gating

  logic adv_en;

  assign adv_en = feature_enable_b_r[`BIT_STEP_ADV_EN];

  // options only act under the advanced step enable
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      false_step_reject_active <= 1'b0;
      advanced_detect_active   <= 1'b0;
    end
    else
    begin
      false_step_reject_active <= adv_en & step_command_r.false_step_reject_en;
      advanced_detect_active   <= adv_en & step_command_r.false_step_reject_en
                                  & step_command_r.advanced_detect_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // long counter match

  logic lc_equal;
  logic lc_equal_r;
  logic lc_match;

  assign lc_equal = (long_count == lc_limit);
  assign lc_match = lc_equal & ~lc_equal_r;

  // remembers equality so only the moment it becomes true fires
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      lc_equal_r <= 1'b1;
    end
    else
    begin
      lc_equal_r <= lc_equal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step window timebase

  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_r;
  logic                           tick;
  logic [15:0]                    window_ticks_r;
  logic                           window_expired;

  assign tick = (tick_cnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
  assign window_expired = (window_period != 16'h0000) && (window_ticks_r >= window_period);

  // prescaler producing one tick per window unit
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      tick_cnt_r <= '0;
    end
    else
    begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // units elapsed since the last step, saturating
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      window_ticks_r <= 16'h0000;
    end
    else if (step_detected || (tick && window_ticks_r != 16'hffff))
    begin
      window_ticks_r <= step_detected ? 16'h0000 : window_ticks_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step debounce and counter

  logic [7:0]  deb_cnt_r;
  logic        deb_done;
  logic        step_inc;
  logic        step_ovf;
  logic [15:0] step_count_r;

  assign deb_done = (deb_cnt_r >= step_debounce_r);
  assign step_inc = step_detected & deb_done;
  assign step_ovf = step_inc & (step_count_r == 16'hffff);

  // steps seen since the walk began, held at the debounce number; a gap past the window restarts it
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      deb_cnt_r <= `RST_ZERO;
    end
    else if (window_expired)
    begin
      deb_cnt_r <= step_detected ? 8'h01 : `RST_ZERO; // gap-ending step opens the walk
    end
    else if (step_detected && !deb_done)
    begin
      deb_cnt_r <= deb_cnt_r + 8'h01;
    end
  end

  // counted steps, wrapping on overflow
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      step_count_r <= 16'h0000;
      step_count   <= 16'h0000;
    end
    else
    begin
      if (step_inc)
      begin
        step_count_r <= step_count_r + 16'h0001;
      end
      step_count <= step_count_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and output

  logic [7:0] irq_status_r;
  logic [7:0] irq_set;
  logic [7:0] irq_status_nxt;
  logic       status_rd;

  assign status_rd = rd_en && (reg_req.addr == `OFS_IRQ_STATUS);

  // event bits; step interrupt suppressed in overflow-only mode
  always_comb
  begin
    irq_set = 8'h00;
    irq_set[`BIT_IRQ_LC_MATCH] = lc_match;
    irq_set[`BIT_IRQ_STEP]     = step_inc & ~step_command_r.carry_count_en;
    irq_set[`BIT_IRQ_STEP_OVF] = step_ovf;
    irq_status_nxt = (status_rd ? 8'h00 : irq_status_r) | irq_set;
  end

  // sticky status, cleared by read; a new event wins over the clear
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      irq_status_r <= `RST_ZERO;
    end
    else
    begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_status_nxt & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  // answer in the cycle after the read strobe, zero otherwise
  always_ff @(posedge core_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rd_data <= `RST_ZERO;
    end
    else if (rd_en)
    begin
      case (reg_req.addr)
        `OFS_FEATURE_ENABLE_B: rd_data <= feature_enable_b_r;
        `OFS_LC_LIMIT_LO:      rd_data <= long_count_limit_lo_r;
        `OFS_LC_LIMIT_HI:      rd_data <= long_count_limit_hi_r;
        `OFS_PROGRAM_COUNT:    rd_data <= program_count_r;
        `OFS_PROGRAM_BASE_LO:  rd_data <= program_base_lo_r;
        `OFS_PROGRAM_BASE_HI:  rd_data <= program_base_hi_r;
        `OFS_STEP_COMMAND:     rd_data <= step_command_r;
        `OFS_STEP_DEBOUNCE:    rd_data <= step_debounce_r;
        `OFS_STEP_WINDOW_LO:   rd_data <= step_window_lo_r;
        `OFS_STEP_WINDOW_HI:   rd_data <= step_window_hi_r;
        `OFS_IRQ_STATUS:       rd_data <= irq_status_r;
        `OFS_IRQ_MASK:         rd_data <= irq_mask_r;
        `OFS_CAL_TRIM:         rd_data <= cal_trim_r;
        default:               rd_data <= `RST_ZERO;
      endcase
    end
    else
    begin
      rd_data <= `RST_ZERO;
    end
  end

endmodule : motion_fsm_pedometer_config

/* File: motion_cfg_props.sv */
// Purpose: port checker for the motion configuration bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every instance of the bank
`timescale 1ns/1ps
`include "motion_cfg_params.svh"

module motion_cfg_props
  import motion_cfg_pkg::*;
#(
  parameter int unsigned TICK_CYCLES      = 4,
  parameter logic [7:0]  CAL_TRIM_DEFAULT = 8'h5a
)
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        arst_n,
  // register port
  input wire reg_req_t    reg_req,
  input wire logic [7:0]  rd_data,
  // engine side
  input wire logic [15:0] long_count_limit,
  input wire logic [7:0]  program_count,
  input wire logic [15:0] program_base,
  input wire logic        step_detected,
  input wire logic [15:0] step_count
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // register writes seen at the port
  sequence s_lc_lo_wr;
    reg_req.wr && reg_req.addr == `OFS_LC_LIMIT_LO;
  endsequence
  sequence s_base_hi_wr;
    reg_req.wr && reg_req.addr == `OFS_PROGRAM_BASE_HI;
  endsequence

  // mirrors follow a write two edges later, byte in place
  property p_lc_lo;
    s_lc_lo_wr |-> ##2 long_count_limit[7:0] == $past(reg_req.wdata, 2);
  endproperty
  property p_base_hi;
    s_base_hi_wr |-> ##2 program_base[15:8] == $past(reg_req.wdata, 2);
  endproperty
  property p_lim_src;
    $changed(long_count_limit) |-> $past(reg_req.wr, 2);
  endproperty
  // read data only in the cycle after a read
  property p_rd_idle;
    !$past(reg_req.rd) |-> rd_data == 8'h00;
  endproperty
  property p_prog_rd;
    reg_req.rd && reg_req.addr == `OFS_PROGRAM_COUNT |=> rd_data == program_count;
  endproperty
  property p_cmd_rsvd;
    reg_req.rd && reg_req.addr == `OFS_STEP_COMMAND |=> rd_data[7:4] == 4'h0 && !rd_data[1];
  endproperty
  property p_unmapped;
    reg_req.rd && reg_req.addr == 8'h00 |=> rd_data == 8'h00;
  endproperty
  // step count moves by one, two edges after a step pulse
  property p_step_inc;
    $changed(step_count) |-> step_count == 16'($past(step_count) + 16'h1);
  endproperty
  property p_step_cause;
    $changed(step_count) |-> $past(step_detected, 2);
  endproperty

  a_lc_lo: assert property (p_lc_lo) else $error("limit low byte wrong");
  a_base_hi: assert property (p_base_hi) else $error("base high byte wrong");
  a_lim_src: assert property (p_lim_src) else $error("limit moved unasked");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_prog_rd: assert property (p_prog_rd) else $error("program count mismatch");
  a_cmd_rsvd: assert property (p_cmd_rsvd) else $error("reserved bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_step_inc: assert property (p_step_inc) else $error("step count jump");
  a_step_cause: assert property (p_step_cause) else $error("step count no cause");
endmodule : motion_cfg_props

bind motion_fsm_pedometer_config motion_cfg_props #(
  .TICK_CYCLES(TICK_CYCLES), .CAL_TRIM_DEFAULT(CAL_TRIM_DEFAULT)
) props_i (.core_clk(core_clk), .arst_n(arst_n), .reg_req(reg_req), .rd_data(rd_data),
  .long_count_limit(long_count_limit), .program_count(program_count),
  .program_base(program_base), .step_detected(step_detected), .step_count(step_count));

/* File: motion_fsm_pedometer_config_tb.sv */
// Purpose: self-checking bench for the motion configuration bank
// Assumes: step tick shortened to 4 core clocks
// Notes:   integer model of registers, status and step counting
`timescale 1ns/1ps
`include "motion_cfg_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

module motion_fsm_pedometer_config_tb
  import motion_cfg_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  reg_req_t    reg_req = '0;
  logic [15:0] long_count = '0;
  logic        step_detected = 1'b0;
  logic [7:0]  rd_data, cal_trim, program_count, q;
  logic [15:0] long_count_limit, program_base, step_count;
  logic        false_step_reject_active, advanced_detect_active, irq;
  int          bad_count = 0;
  int          n_checks = 0;
  int          mdl [logic [7:0]];
  int          steps, deb, dval, v;
  logic [7:0]  offs [12] = '{8'h05, 8'h7a, 8'h7b, 8'h7c, 8'h7e, 8'h7f, 8'h83, 8'h84,
                             8'hd0, 8'hd1, 8'he1, 8'he2};

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  motion_fsm_pedometer_config #(.TICK_CYCLES(4)) motion_fsm_pedometer_config_i (
    .core_clk(core_clk), .arst_n(arst_n), .reg_req(reg_req), .rd_data(rd_data),
    .long_count(long_count), .long_count_limit(long_count_limit),
    .program_count(program_count), .program_base(program_base),
    .step_detected(step_detected), .step_count(step_count),
    .false_step_reject_active(false_step_reject_active),
    .advanced_detect_active(advanced_detect_active), .cal_trim(cal_trim), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // register port cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task automatic chk_rd(input logic [7:0] a, input int e);
    rd(a, q);
    `CHK(q, 8'(e))
  endtask : chk_rd

  // n back-to-back step cycles, model updated alongside
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++)
      if (deb < dval) deb++;
      else steps++;
    @(posedge core_clk);
    step_detected <= 1'b1;
    repeat (n) @(posedge core_clk);
    step_detected <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : pulses

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end

  // main sequence
  initial
  begin
    void'($urandom(79));
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK(cal_trim, 8'h5a)
    foreach (offs[i]) mdl[offs[i]] = 0;
    mdl[8'h84] = 8'h0a;
    mdl[8'he2] = 8'h5a;
    foreach (offs[i]) chk_rd(offs[i], mdl[offs[i]]);
    chk_rd(8'he0, 0);
    chk_rd(8'h00, 0);
    $display("test reset values done");
    // random contents, readback and mirrors
    repeat (4)
    begin
      foreach (offs[i])
      begin
        v = $urandom & 8'hff;
        if (offs[i] == 8'h83) v = v & 8'h0d;
        if (offs[i] == 8'h7c) v = v % 17;
        if (offs[i] == 8'h7f) v = v | 8'h04;
        mdl[offs[i]] = v;
        wr(offs[i], 8'(v));
      end
      foreach (offs[i]) chk_rd(offs[i], mdl[offs[i]]);
      `CHK(long_count_limit, 16'(mdl[8'h7b] * 256 + mdl[8'h7a]))
      `CHK(program_base, 16'(mdl[8'h7f] * 256 + mdl[8'h7e]))
      `CHK(program_count, 8'(mdl[8'h7c]))
    end
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK(cal_trim, 8'h5a)
    chk_rd(8'h7b, 0);
    chk_rd(8'he0, 0);
    $display("test random registers done");
    // enable combinations
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h05, {4'h0, i[2], 3'h0});
      wr(8'h83, {5'h00, i[1], 1'b0, i[0]});
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(false_step_reject_active, 1'(i[2] & i[1]))
      `CHK(advanced_detect_active, 1'(i[2] & i[1] & i[0]))
    end
    $display("test enables done");
    // long counter match, unmasked then masked
    v = $urandom & 16'hffff;
    wr(8'he1, 8'h01);
    @(posedge core_clk);
    long_count <= 16'(v + 1);
    wr(8'h7a, 8'(v));
    wr(8'h7b, 8'(v >> 8));
    rd(8'he0, q);
    @(posedge core_clk);
    long_count <= 16'(v);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(irq, 1'b1)
    chk_rd(8'he0, 1);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(irq, 1'b0)
    wr(8'he1, 8'h00);
    long_count <= 16'(v + 1);
    @(posedge core_clk);
    long_count <= 16'(v);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(irq, 1'b0)
    chk_rd(8'he0, 1);
    $display("test long counter done");
    // debounce, window and overflow-only interrupt
    dval = 1 + $urandom % 5;
    steps = 0;
    deb = 0;
    wr(8'h84, 8'(dval));
    wr(8'h83, 8'h00);
    wr(8'he1, 8'h06);
    for (int i = 0; i < dval + 2; i++) pulses(1);
    `CHK(step_count, 16'(steps))
    repeat (40) @(posedge core_clk);
    pulses(1);
    `CHK(step_count, 16'(steps))
    wr(8'hd0, 8'h02);
    repeat (40) @(posedge core_clk);
    deb = 0;
    pulses(1);
    `CHK(step_count, 16'(steps))
    `CHK(irq, 1'b1)
    chk_rd(8'he0, 8'h02);
    wr(8'hd0, 8'h00);
    wr(8'h84, 8'h00);
    wr(8'h83, 8'h08);
    dval = 0;
    pulses(65538 - steps);
    `CHK(step_count, 16'(steps))
    chk_rd(8'he0, 8'h04);
    $display("test pedometer done");
    complete_run();
  end
endmodule : motion_fsm_pedometer_config_tb
